/* include/udc_dma_map.svh */
// Purpose: Constants for the USB integrated DMA channel logic
// Assumes: Byte counts, 32-bit memory words
// Notes: Included by the design files and the package
`ifndef UDC_DMA_MAP_SVH
`define UDC_DMA_MAP_SVH
`define UDC_NUM_CH 4
`define UDC_CH_W 2
`define UDC_CNT_W 16
`define UDC_PKT_W 11
`define UDC_WORD_BYTES 3'h4
`define UDC_ADDR_STEP 32'h4
`define UDC_ALIGN_MASK 32'hffff_fffc
`define UDC_BURST_NONE 2'h0
`define UDC_BURST_4 2'h1
`define UDC_BURST_8 2'h2
`define UDC_BURST_16 2'h3
`define UDC_BEATS_1 5'h01
`define UDC_BEATS_4 5'h04
`define UDC_BEATS_8 5'h08
`define UDC_BEATS_16 5'h10
`define UDC_BUF_W 35
`endif

/* include/udc_dma_pkg.sv */
// Purpose: Types for the USB integrated DMA channel logic
// Assumes: Included map header holds every number
// Notes: State encoding left to the tool
`include "udc_dma_map.svh"
package udc_dma_pkg;
  typedef enum logic [2:0] {
    UDC_IDLE,
    UDC_TX_SPACE,
    UDC_TX_READ,
    UDC_RX_ARM,
    UDC_RX_DRAIN
  } udc_state_t;
  typedef logic [`UDC_CNT_W-1:0] udc_count_t;
  typedef logic [`UDC_PKT_W-1:0] udc_pkt_t;
endpackage : udc_dma_pkg

/* logic/udc_skid_buf.sv */
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, asynchronous active-low reset
// Notes: Ready and valid come straight from flip-flops
`timescale 1ns/100ps
`include "udc_dma_map.svh"
module udc_skid_buf #(
  parameter int W = `UDC_BUF_W
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  logic [W-1:0] tail_reg;
  logic tail_valid_reg;
  logic push;
  logic pop;
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_out_valid <= 1'b0;
      o_out_data <= '0;
      tail_valid_reg <= 1'b0;
      tail_reg <= '0;
      o_in_ready <= 1'b1;
    end else if (pop) begin
      if (tail_valid_reg) begin
        o_out_data <= tail_reg;
        tail_valid_reg <= push;
        o_in_ready <= !push;
        if (push) begin
          tail_reg <= i_in_data;
        end
      end else begin
        o_out_valid <= push;
        if (push) begin
          o_out_data <= i_in_data;
        end
      end
    end else if (push) begin
      if (!o_out_valid) begin
        o_out_valid <= 1'b1;
        o_out_data <= i_in_data;
      end else begin
        tail_valid_reg <= 1'b1;
        tail_reg <= i_in_data;
        o_in_ready <= 1'b0;
      end
    end
  end
endmodule : udc_skid_buf

/* logic/udc_dma_core.sv */
// Purpose: Integrated DMA engine between memory and endpoint FIFOs
// Assumes: One transfer in flight at a time, 32-bit memory words
// Notes: Both directions pass through one two-entry buffer
// Functional notes
// - Transmit FIFO filled in max-packet chunks
// - Auto transmit sends each full packet
// - Completion raises USB interrupt, status separate
// - Status read clears all channel flags except one set in the same cycle
// - Whole-multiple transmit ends at DMA completion
// - Auto acknowledge when last byte drained
// - DMA-enabled endpoint suppresses full-packet interrupt
// - Mode 1 receive starts on full packet
// - Short packet: no DMA, interrupt raised
// - Host auto request issues next IN
// - Per-channel interrupt enable gates completion
// - Global status readable, cleared separately
// - Memory accesses word aligned only
// - Mode 0 per packet, mode 1 per transfer
// - Burst none, four, eight or sixteen words
// - Byte count; direction selects data path
`timescale 1ns/100ps
`include "udc_dma_map.svh"
module udc_dma_core
  import udc_dma_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Channel programming
  input wire logic i_ch_start,
  input wire logic [`UDC_CH_W-1:0] i_ch_sel,
  input wire logic i_ch_dir_tx,
  input wire logic i_ch_mode1,
  input wire logic [1:0] i_ch_burst,
  input wire logic [31:0] i_ch_addr,
  input wire udc_dma_pkg::udc_count_t i_ch_count,
  input wire logic [`UDC_NUM_CH-1:0] i_ch_int_en,
  // Endpoint configuration
  input wire udc_dma_pkg::udc_pkt_t i_max_pkt,
  input wire logic i_endpoint_dma_enable,
  input wire logic i_endpoint_dma_multi_packet_mode,
  input wire logic i_endpoint_in_direction,
  input wire logic i_auto_transmit_full_packet,
  input wire logic i_auto_acknowledge_on_drain,
  input wire logic i_auto_in_request,
  input wire logic i_host_mode,
  // Status access
  input wire logic i_int_status_rd,
  input wire logic i_status_clr,
  output logic [`UDC_NUM_CH-1:0] o_int_status,
  output logic o_dma_error,
  output logic o_usb_irq,
  output logic o_busy,
  // Memory port
  output logic o_mem_rd_req,
  output logic [31:0] o_mem_addr,
  output logic [4:0] o_mem_burst_len,
  output logic o_mem_burst_first,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  input wire logic i_mem_wready,
  input wire logic i_mem_err,
  // Shared buffer output: FIFO when transmitting, memory otherwise
  output logic o_out_valid,
  output logic [31:0] o_out_data,
  output logic [2:0] o_out_bytes,
  output logic o_out_to_fifo,
  input wire logic i_fifo_wready,
  input wire logic i_tx_fifo_space,
  output logic o_tx_pkt_send,
  // Receive FIFO side
  input wire logic i_fifo_rvalid,
  input wire logic [31:0] i_fifo_rdata,
  output logic o_fifo_rready,
  input wire logic i_rx_pkt_valid,
  input wire udc_dma_pkg::udc_pkt_t i_rx_pkt_bytes,
  output logic o_rx_ack,
  output logic o_in_request,
  output logic o_ep_pkt_irq
);
  udc_state_t state_reg;
  logic [`UDC_CH_W-1:0] ch_reg;
  logic mode1_reg;
  logic [1:0] burst_reg;
  udc_count_t rem_reg;
  udc_count_t sink_rem_reg;
  udc_pkt_t chunk_reg;
  udc_pkt_t pkt_reg;
  logic [4:0] beat_reg;
  logic [`UDC_NUM_CH-1:0] flag_reg;
  logic [`UDC_NUM_CH-1:0] flag_next;
  logic buf_in_valid;
  logic [`UDC_BUF_W-1:0] buf_in_data;
  logic buf_in_ready;
  logic [`UDC_BUF_W-1:0] buf_out_data;
  logic sink_ready;
  logic fire;
  logic [2:0] src_nb;
  logic [2:0] nb;
  udc_pkt_t pkt_sum;
  logic pkt_full;
  logic xfer_end;
  logic pkt_end;
  logic done_evt;
  logic fifo_pop;
  logic [4:0] burst_words;

  // Bytes carried by the next source word: four, or the tail
  assign src_nb = (rem_reg >= udc_count_t'(`UDC_WORD_BYTES)) ?
    `UDC_WORD_BYTES : rem_reg[2:0];
  assign fifo_pop = o_fifo_rready & i_fifo_rvalid;
  assign buf_in_valid = o_out_to_fifo ? (o_mem_rd_req & i_mem_ack) :
    fifo_pop;
  assign buf_in_data = {src_nb,
    (o_out_to_fifo ? i_mem_rdata : i_fifo_rdata)};
  assign sink_ready = o_out_to_fifo ? i_fifo_wready : i_mem_wready;
  assign o_out_data = buf_out_data[31:0];
  assign o_out_bytes = buf_out_data[34:32];
  assign nb = buf_out_data[34:32];
  assign fire = o_out_valid & sink_ready;
  assign pkt_sum = pkt_reg + udc_pkt_t'(nb);
  assign pkt_full = (pkt_sum == i_max_pkt);
  assign xfer_end = fire & (sink_rem_reg == udc_count_t'(nb));
  assign pkt_end = fire & (pkt_full | xfer_end);
  // Mode 0 flags each packet, mode 1 only the whole transfer
  assign done_evt = xfer_end | (pkt_end & !mode1_reg);

  always_comb begin
    unique case (burst_reg)
      `UDC_BURST_4: burst_words = `UDC_BEATS_4;
      `UDC_BURST_8: burst_words = `UDC_BEATS_8;
      `UDC_BURST_16: burst_words = `UDC_BEATS_16;
      default: burst_words = `UDC_BEATS_1;
    endcase
  end

  udc_skid_buf #(
    .W(`UDC_BUF_W)
  ) u_buf (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_in_valid(buf_in_valid),
    .i_in_data(buf_in_data),
    .o_in_ready(buf_in_ready),
    .o_out_valid(o_out_valid),
    .o_out_data(buf_out_data),
    .i_out_ready(sink_ready)
  );

  // Sequencing, source-side counters and memory address
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= UDC_IDLE;
      ch_reg <= '0;
      mode1_reg <= 1'b0;
      burst_reg <= `UDC_BURST_NONE;
      o_out_to_fifo <= 1'b0;
      rem_reg <= '0;
      chunk_reg <= '0;
      o_mem_addr <= '0;
      o_busy <= 1'b0;
    end else if (i_mem_err) begin
      state_reg <= UDC_IDLE;
      o_busy <= 1'b0;
    end else begin
      unique case (state_reg)
        UDC_IDLE: begin
          if (i_ch_start) begin
            ch_reg <= i_ch_sel;
            mode1_reg <= i_ch_mode1;
            burst_reg <= i_ch_burst;
            o_out_to_fifo <= i_ch_dir_tx;
            rem_reg <= i_ch_count;
            o_mem_addr <= i_ch_addr & `UDC_ALIGN_MASK;
            o_busy <= (i_ch_count != '0);
            if (i_ch_count != '0) begin
              state_reg <= i_ch_dir_tx ? UDC_TX_SPACE : UDC_RX_ARM;
            end
          end
        end
        UDC_TX_SPACE: begin
          // Next chunk waits until a whole packet fits
          if (rem_reg != '0 && i_tx_fifo_space) begin
            chunk_reg <= (rem_reg > udc_count_t'(i_max_pkt)) ?
              i_max_pkt : udc_pkt_t'(rem_reg);
            state_reg <= UDC_TX_READ;
          end
        end
        UDC_TX_READ: begin
          if (o_mem_rd_req && i_mem_ack) begin
            rem_reg <= rem_reg - udc_count_t'(src_nb);
            chunk_reg <= chunk_reg - udc_pkt_t'(src_nb);
            o_mem_addr <= o_mem_addr + `UDC_ADDR_STEP;
            if (chunk_reg <= udc_pkt_t'(src_nb)) begin
              state_reg <= UDC_TX_SPACE;
            end
          end
        end
        UDC_RX_ARM: begin
          if (!i_endpoint_dma_enable) begin
            // Packet already waiting; software started on its interrupt
            chunk_reg <= (rem_reg > udc_count_t'(i_max_pkt)) ?
              i_max_pkt : udc_pkt_t'(rem_reg);
            state_reg <= UDC_RX_DRAIN;
          end else if (i_rx_pkt_valid && i_rx_pkt_bytes == i_max_pkt &&
              i_endpoint_dma_multi_packet_mode) begin
            chunk_reg <= i_max_pkt;
            state_reg <= UDC_RX_DRAIN;
          end
        end
        UDC_RX_DRAIN: begin
          if (fifo_pop) begin
            rem_reg <= rem_reg - udc_count_t'(src_nb);
            chunk_reg <= chunk_reg - udc_pkt_t'(src_nb);
            if (chunk_reg <= udc_pkt_t'(src_nb)) begin
              state_reg <= UDC_RX_ARM;
            end
          end
        end
      endcase
      if (!o_out_to_fifo && fire) begin
        o_mem_addr <= o_mem_addr + `UDC_ADDR_STEP;
      end
      if (xfer_end) begin
        state_reg <= UDC_IDLE;
        o_busy <= 1'b0;
      end
    end
  end

  // Source strobes: one word in flight keeps the buffer from overrun
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mem_rd_req <= 1'b0;
      o_fifo_rready <= 1'b0;
      o_mem_burst_len <= `UDC_BEATS_1;
      o_mem_burst_first <= 1'b0;
      beat_reg <= '0;
    end else begin
      o_fifo_rready <= (state_reg == UDC_RX_DRAIN) && buf_in_ready &&
        i_fifo_rvalid && !o_fifo_rready && chunk_reg != '0 &&
        !(fifo_pop && chunk_reg <= udc_pkt_t'(src_nb));
      if (o_mem_rd_req) begin
        o_mem_burst_first <= 1'b0;
        if (i_mem_ack || i_mem_err) begin
          o_mem_rd_req <= 1'b0;
        end
      end else if (state_reg == UDC_TX_READ && buf_in_ready &&
          chunk_reg != '0 && !i_mem_err) begin
        o_mem_rd_req <= 1'b1;
        o_mem_burst_first <= (beat_reg == '0);
        o_mem_burst_len <= burst_words;
        beat_reg <= (beat_reg == '0) ? burst_words - 5'h01 :
          beat_reg - 5'h01;
      end
    end
  end

  // Sink-side packet tracking and endpoint strobes
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pkt_reg <= '0;
      sink_rem_reg <= '0;
      o_tx_pkt_send <= 1'b0;
      o_rx_ack <= 1'b0;
      o_in_request <= 1'b0;
      o_ep_pkt_irq <= 1'b0;
    end else begin
      if (state_reg == UDC_IDLE && i_ch_start) begin
        sink_rem_reg <= i_ch_count;
        pkt_reg <= '0;
      end else if (fire) begin
        sink_rem_reg <= sink_rem_reg - udc_count_t'(nb);
        pkt_reg <= pkt_end ? '0 : pkt_sum;
      end
      // Short final transmit packet is left for software to send
      o_tx_pkt_send <= o_out_to_fifo && fire && pkt_full &&
        i_auto_transmit_full_packet;
      o_rx_ack <= !o_out_to_fifo && pkt_end &&
        i_auto_acknowledge_on_drain;
      o_in_request <= !o_out_to_fifo && pkt_end && !xfer_end &&
        i_host_mode && i_auto_in_request &&
        i_endpoint_in_direction;
      // Packet interrupt only when DMA will not take the packet
      o_ep_pkt_irq <= i_rx_pkt_valid && (!i_endpoint_dma_enable ||
        i_rx_pkt_bytes != i_max_pkt);
    end
  end

  // Per-channel completion flags; set beats the read-clear
  generate
    for (genvar c = 0; c < `UDC_NUM_CH; c++) begin : g_flag
      always_comb begin
        flag_next[c] = flag_reg[c];
        if (i_int_status_rd) begin
          flag_next[c] = 1'b0;
        end
        if (done_evt && ch_reg == `UDC_CH_W'(c) && i_ch_int_en[c]) begin
          flag_next[c] = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flag_reg <= '0;
      o_int_status <= '0;
      o_usb_irq <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      if (i_int_status_rd) begin
        o_int_status <= flag_reg;
      end
      o_usb_irq <= (|flag_next) | o_ep_pkt_irq;
    end
  end

  // Global status: sticky error, cleared by its own strobe
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dma_error <= 1'b0;
    end else if (i_mem_err) begin
      o_dma_error <= 1'b1;
    end else if (i_status_clr) begin
      o_dma_error <= 1'b0;
    end
  end
endmodule : udc_dma_core

/* verif/udc_dma_checker.sv */
// Purpose: Port assertions for the DMA core
// Assumes: One clock, async active-low reset
// Notes: Bound to every core instance
`timescale 1ns/100ps
module udc_dma_checker
  import udc_dma_pkg::*;
(
  // Clock, reset, programming
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ch_start,
  input wire udc_dma_pkg::udc_count_t i_ch_count,
  input wire logic o_busy,
  // Memory and sink
  input wire logic o_mem_rd_req,
  input wire logic i_mem_ack,
  input wire logic [31:0] o_mem_addr,
  input wire logic [4:0] o_mem_burst_len,
  input wire logic o_mem_burst_first,
  input wire logic o_out_valid,
  input wire logic [31:0] o_out_data,
  input wire logic o_out_to_fifo,
  input wire logic i_fifo_wready,
  input wire logic i_mem_wready,
  input wire logic i_mem_err,
  // Endpoint and status
  input wire logic o_fifo_rready,
  input wire logic o_rx_ack,
  input wire logic i_auto_acknowledge_on_drain,
  input wire logic o_tx_pkt_send,
  input wire logic i_auto_transmit_full_packet,
  input wire logic i_status_clr,
  input wire logic o_dma_error
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic sink_rdy;
  assign sink_rdy = o_out_to_fifo ? i_fifo_wready : i_mem_wready;
  a_start_busy: assert property (
    i_ch_start && !o_busy && i_ch_count != '0 |=> o_busy)
    else $error("start not taken");
  a_req_hold: assert property (
    o_mem_rd_req && !i_mem_ack && !i_mem_err
    |=> o_mem_rd_req && $stable(o_mem_addr))
    else $error("read request dropped");
  a_addr_align: assert property (
    o_mem_rd_req |-> o_mem_addr[1:0] == 2'h0)
    else $error("unaligned read");
  a_burst_legal: assert property (
    o_mem_rd_req && o_mem_burst_first
    |-> o_mem_burst_len inside {5'h01, 5'h04, 5'h08, 5'h10})
    else $error("bad burst length");
  a_out_hold: assert property (
    o_out_valid && !sink_rdy && !i_mem_err
    |=> o_out_valid && $stable(o_out_data))
    else $error("word lost on stall");
  a_pop_pulse: assert property (
    o_fifo_rready |=> !o_fifo_rready)
    else $error("pop longer than one cycle");
  a_ack_gated: assert property (
    o_rx_ack |-> i_auto_acknowledge_on_drain)
    else $error("ack without auto option");
  a_send_gated: assert property (
    o_tx_pkt_send |-> i_auto_transmit_full_packet)
    else $error("send without auto option");
  a_err_clear: assert property (
    i_status_clr && !i_mem_err |=> !o_dma_error)
    else $error("error flag not cleared");
  c_send: cover property (o_tx_pkt_send);
  c_ack: cover property (o_rx_ack);
  c_err: cover property (o_dma_error);
endmodule : udc_dma_checker

bind udc_dma_core udc_dma_checker udc_dma_checker_inst (
  .i_sys_clk, .i_rstn, .i_ch_start, .i_ch_count, .o_busy, .o_mem_rd_req,
  .i_mem_ack, .o_mem_addr, .o_mem_burst_len, .o_mem_burst_first,
  .o_out_valid, .o_out_data, .o_out_to_fifo, .i_fifo_wready,
  .i_mem_wready, .i_mem_err, .o_fifo_rready, .o_rx_ack,
  .i_auto_acknowledge_on_drain, .o_tx_pkt_send,
  .i_auto_transmit_full_packet, .i_status_clr, .o_dma_error);

/* verif/udc_ep_model.sv */
// Purpose: Endpoint FIFO model facing the DMA core
// Assumes: RX words loaded by the bench, numbered from zero
// Notes: TX side stalls at random; idle read data is inverted
`timescale 1ns/100ps
module udc_ep_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Bench load
  input wire logic i_load,
  input wire logic [7:0] i_load_n,
  // Core side
  input wire logic i_fifo_rready,
  output logic o_fifo_rvalid,
  output logic [31:0] o_fifo_rdata,
  output logic o_fifo_wready,
  output logic o_tx_fifo_space
);
  logic [7:0] left_reg;
  logic [31:0] idx_reg;
  assign o_fifo_rvalid = left_reg != 8'h00;
  // Empty FIFO must not look like a held word
  assign o_fifo_rdata = o_fifo_rvalid ? 32'hc0de_0000 + idx_reg
                                      : ~(32'hc0de_0000 + idx_reg);
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      left_reg <= 8'h00;
      idx_reg <= 32'h0;
      o_fifo_wready <= 1'b0;
      o_tx_fifo_space <= 1'b0;
    end else begin
      o_fifo_wready <= $urandom_range(3) != 0;
      o_tx_fifo_space <= $urandom_range(3) != 0;
      if (i_load) begin
        left_reg <= i_load_n;
        idx_reg <= 32'h0;
      end else if (i_fifo_rready && o_fifo_rvalid) begin
        left_reg <= left_reg - 8'h01;
        idx_reg <= idx_reg + 32'h1;
      end
    end
  end
endmodule : udc_ep_model

/* verif/tb.sv */
// Purpose: Self-checking bench for the DMA core
// Assumes: Memory answered here, FIFOs by the model
// Notes: Random stalls, fixed seed
`timescale 1ns/100ps
`include "udc_dma_map.svh"
module tb;
  import udc_dma_pkg::*;
  logic clk, rstn, start, dtx, m1, rd, clr, ack, wrdy, err, pv, ld;
  logic epd, epm, ind, at, aa, host, areq, rreq, bf, ov, tof, snd;
  logic rr, rxa, inr, epi, derr, irq, busy, rv, fw, sp;
  logic [1:0] sel, bur;
  logic [2:0] ob;
  logic [3:0] ien, st, acc;
  logic [4:0] bl;
  logic [7:0] ldn;
  logic [31:0] addr, rdat, maddr, od, frd, base;
  udc_count_t cnt, c;
  udc_pkt_t mp, pb;
  int n_mismatch, tests_run, k, nsnd, nepi, nrxa, ninr, i, n;
  udc_dma_core udc_dma_core_inst (.i_sys_clk(clk), .i_rstn(rstn),
    .i_ch_start(start), .i_ch_sel(sel), .i_ch_dir_tx(dtx), .i_ch_mode1(m1),
    .i_ch_burst(bur), .i_ch_addr(addr), .i_ch_count(cnt), .i_ch_int_en(ien),
    .i_max_pkt(mp), .i_endpoint_dma_enable(epd),
    .i_endpoint_dma_multi_packet_mode(epm), .i_endpoint_in_direction(ind),
    .i_auto_transmit_full_packet(at), .i_auto_acknowledge_on_drain(aa),
    .i_auto_in_request(areq), .i_host_mode(host), .i_int_status_rd(rd),
    .i_status_clr(clr), .o_int_status(st), .o_dma_error(derr),
    .o_usb_irq(irq), .o_busy(busy), .o_mem_rd_req(rreq), .o_mem_addr(maddr),
    .o_mem_burst_len(bl), .o_mem_burst_first(bf), .i_mem_ack(ack),
    .i_mem_rdata(rdat), .i_mem_wready(wrdy), .i_mem_err(err),
    .o_out_valid(ov), .o_out_data(od), .o_out_bytes(ob), .o_out_to_fifo(tof),
    .i_fifo_wready(fw), .i_tx_fifo_space(sp), .o_tx_pkt_send(snd),
    .i_fifo_rvalid(rv), .i_fifo_rdata(frd), .o_fifo_rready(rr),
    .i_rx_pkt_valid(pv), .i_rx_pkt_bytes(pb), .o_rx_ack(rxa),
    .o_in_request(inr), .o_ep_pkt_irq(epi));
  udc_ep_model udc_ep_model_inst (.i_sys_clk(clk), .i_rstn(rstn),
    .i_load(ld), .i_load_n(ldn), .i_fifo_rready(rr), .o_fifo_rvalid(rv),
    .o_fifo_rdata(frd), .o_fifo_wready(fw), .o_tx_fifo_space(sp));
  function automatic logic [31:0] mw(input logic [31:0] a);
    return a ^ 32'h5a5a_a5a5;
  endfunction : mw
  task automatic chk(input logic [31:0] g, e, input string m);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic tick(input int m);
    repeat (m) @(posedge clk);
    #1;
  endtask : tick
  task automatic pulse_pv();
    @(posedge clk);
    pv <= 1'b1;
    @(posedge clk);
    pv <= 1'b0;
  endtask : pulse_pv
  task automatic go(input logic t, input udc_count_t q, input logic [31:0] a);
    @(posedge clk);
    dtx <= t;
    cnt <= q;
    addr <= a;
    start <= 1'b1;
    k = 0;
    base = a & `UDC_ALIGN_MASK;
    @(posedge clk);
    start <= 1'b0;
    // Busy is only visible once the start edge has settled
    #1;
  endtask : go
  task automatic wt();
    for (i = 0; i < 5000 && busy !== 1'b0; i++) tick(1);
    // Endpoint strobes trail the last word by one edge
    tick(2);
    if (i == 5000) begin
      n_mismatch++;
      stop_test();
    end
  endtask : wt
  task automatic rdst(input logic [3:0] e);
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(32'(st), 32'(e), "status");
  endtask : rdst
  // Memory: slow read answers, random write stalls
  always @(posedge clk) begin
    ack <= rreq === 1'b1 && !ack && $urandom_range(1) == 1;
    rdat <= (rreq === 1'b1 && !ack) ? mw(maddr) : ~rdat;
    wrdy <= $urandom_range(1) == 1;
    nsnd += int'(snd === 1'b1);
    nepi += int'(epi === 1'b1);
    nrxa += int'(rxa === 1'b1);
    ninr += int'(inr === 1'b1);
  end
  always @(posedge clk) if (ov === 1'b1 && (tof ? fw : wrdy) === 1'b1) begin
    if (tof) chk(od, mw(base + 32'(4 * k)), "tx data");
    else chk(od, 32'hc0de_0000 + 32'(k), "rx data");
    if (!tof) chk(maddr, base + 32'(4 * k), "rx addr");
    chk(32'(ob), (k == (cnt + 3) / 4 - 1 && cnt % 4 != 0) ? 32'(cnt % 4)
        : 32'h4, "bytes");
    k++;
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    {rstn, start, dtx, m1, rd, clr, err, pv, ld} = '0;
    {epd, epm, ind, at, aa, host, areq, sel, bur, ien, acc} = '0;
    {ldn, addr, cnt, pb} = '0;
    mp = 11'h040;
    void'($urandom(13743));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int t = 0; t < 6; t++) begin
      n = nsnd;
      c = t == 0 ? 16'h0080 : t == 1 ? 16'h0001 : 16'($urandom_range(1, 200));
      @(posedge clk);
      sel <= 2'($urandom);
      bur <= 2'($urandom);
      m1 <= 1'($urandom);
      at <= 1'($urandom);
      ien <= 4'($urandom);
      go(1'b1, c, $urandom);
      wt();
      chk(nsnd - n, at ? c / mp : 0, "auto sends");
      if (ien[sel]) acc[sel] = 1'b1;
    end
    chk(32'(irq), 32'(acc != 4'h0), "usb irq");
    rdst(acc);
    rdst(4'h0);
    @(posedge clk);
    {sel, ien, m1, aa, ldn, pb, ld} <= {2'h3, 4'h8, 2'b01, 8'h10, mp, 1'b1};
    pulse_pv();
    ld <= 1'b0;
    tick(4);
    chk(nepi, 1, "pkt irq shown");
    go(1'b0, 16'h0040, 32'h0000_2002);
    wt();
    chk(k, 16, "rx words");
    chk(nrxa, 1, "auto ack");
    @(posedge clk);
    {epd, epm, ind, host, areq, aa, m1} <= 7'b1111101;
    {ld, ldn} <= {1'b1, 8'h20};
    @(posedge clk);
    ld <= 1'b0;
    go(1'b0, 16'h0080, 32'h0000_3000);
    tick(8);
    chk(k, 0, "early drain");
    for (int p = 1; p < 3; p++) begin
      pulse_pv();
      for (i = 0; i < 500 && k < 16 * p; i++) tick(1);
      tick(8);
      chk(k, 16 * p, "packet drain");
    end
    wt();
    chk(ninr, 1, "in requests");
    chk(nrxa, 1, "no ack");
    chk(nepi, 1, "pkt irq hidden");
    rdst(4'h8);
    @(posedge clk);
    {ld, ldn, pb} <= {1'b1, 8'h01, 11'h004};
    @(posedge clk);
    ld <= 1'b0;
    go(1'b0, 16'h0040, 32'h0000_4000);
    pulse_pv();
    tick(8);
    chk(nepi, 2, "short irq");
    chk(k, 0, "short no dma");
    chk(nrxa, 1, "short left to software");
    rdst(4'h0);
    @(posedge clk);
    err <= 1'b1;
    @(posedge clk);
    err <= 1'b0;
    tick(1);
    chk(32'({busy, derr}), 32'h1, "abort");
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    tick(1);
    chk(32'(derr), 32'h0, "err clear");
    stop_test();
  end
endmodule : tb
